// ### hw/pdiag_map.svh
`ifndef PDIAG_MAP_SVH
`define PDIAG_MAP_SVH
// register byte offsets
`define PDIAG_CTRL_OFS 12'h000
`define PDIAG_STAT_OFS 12'h004
`define PDIAG_EXT_OFS 12'h008
`define PDIAG_FAILCNT_OFS 12'h00c
`define PDIAG_SNR_OFS 12'h010
`define PDIAG_FLOOR_OFS 12'h014
`define PDIAG_STRAP_OFS 12'h018
// control field positions
`define PDIAG_CTRL_NORMAL 0
`define PDIAG_CTRL_CABLE 1
`define PDIAG_CTRL_LINKEN 2
`define PDIAG_CTRL_LB_LO 3
`define PDIAG_CTRL_LB_HI 4
// external status field positions
`define PDIAG_EXT_UV_A18 0
`define PDIAG_EXT_UV_D18 1
`define PDIAG_EXT_UV_A33 2
`define PDIAG_EXT_OPEN 3
`define PDIAG_EXT_SHORT 4
`define PDIAG_EXT_ILV 5
`define PDIAG_EXT_DONE 6
// reset values
`define PDIAG_CTRL_RST 5'h00
`define PDIAG_FLOOR_RST 8'h20
// timing
`define PDIAG_CLK_HZ 40000000
`define PDIAG_PULSE_HZ_X10 6666000
`define PDIAG_PULSE_CYC 6'd60
`define PDIAG_PROBE_TO_US 100
`define PDIAG_RXFRM_TO_US 100
`define PDIAG_PON_SETTLE_US 100
`endif

// ### hw/pdiag_pkg.sv
package pdiag_pkg;
  typedef enum logic [1:0] {
    PDIAG_LB_NONE = 2'h0,
    PDIAG_LB_INTERNAL = 2'h1,
    PDIAG_LB_EXTERNAL = 2'h2,
    PDIAG_LB_REMOTE = 2'h3
  } pdiag_lb_t;
  typedef enum logic [1:0] {
    PDIAG_IF_MII = 2'h0,
    PDIAG_IF_RMII_OSC = 2'h1,
    PDIAG_IF_RMII_XTAL = 2'h2,
    PDIAG_IF_REV_MII = 2'h3
  } pdiag_if_t;
  typedef struct packed {
    logic [1:0] addr;
    logic role_master;
    logic autonomous;
    pdiag_if_t iface;
  } pdiag_strap_t;
  typedef struct packed {
    logic [1:0] a;
    logic [1:0] b;
    logic valid;
  } pdiag_sym_t;
endpackage

// ### hw/pdiag_top.sv
`timescale 1ns/1ps
`include "pdiag_map.svh"
module pdiag_top
  import pdiag_pkg::*;
#(
  parameter int PROBE_TO_CYC = `PDIAG_PROBE_TO_US * (`PDIAG_CLK_HZ / 1000000),
  parameter int RXFRM_TO_CYC = `PDIAG_RXFRM_TO_US * (`PDIAG_CLK_HZ / 1000000),
  parameter int PON_CYC = `PDIAG_PON_SETTLE_US * (`PDIAG_CLK_HZ / 1000000)
) (
  input wire logic REF_CLK,
  input wire logic RESET,
  input wire logic [11:0] S_AXI_AWADDR,
  input wire logic S_AXI_AWVALID,
  output logic S_AXI_AWREADY,
  input wire logic [31:0] S_AXI_WDATA,
  input wire logic [3:0] S_AXI_WSTRB,
  input wire logic S_AXI_WVALID,
  output logic S_AXI_WREADY,
  output logic [1:0] S_AXI_BRESP,
  output logic S_AXI_BVALID,
  input wire logic S_AXI_BREADY,
  input wire logic [11:0] S_AXI_ARADDR,
  input wire logic S_AXI_ARVALID,
  output logic S_AXI_ARREADY,
  output logic [31:0] S_AXI_RDATA,
  output logic [1:0] S_AXI_RRESP,
  output logic S_AXI_RVALID,
  input wire logic S_AXI_RREADY,
  input wire logic UV_A18,
  input wire logic UV_D18,
  input wire logic UV_A33,
  input wire logic SUPPLIES_OK,
  input wire logic ADDR_STRAP_BIT0,
  input wire logic ADDR_STRAP_BIT1,
  input wire logic ROLE_STRAP,
  input wire logic OPERATION_STRAP,
  input wire logic IFACE_STRAP_LOW,
  input wire logic IFACE_STRAP_HIGH,
  input wire logic [4:0] MGMT_ADDR,
  output logic MGMT_ADDR_HIT,
  input wire logic [7:0] SNR_IN,
  input wire logic ECHO_OPEN,
  input wire logic ECHO_SHORT,
  input wire pdiag_sym_t TX_SYM,
  input wire pdiag_sym_t LINE_SYM,
  input wire logic END_DELIM_FIRST,
  input wire logic END_DELIM_SECOND,
  input wire logic RX_START,
  output pdiag_sym_t PCS_RX_SYM,
  output pdiag_sym_t LINE_TX_SYM,
  output logic LINE_RX_FROM_TX,
  output logic PROBE_PULSE,
  output logic TX_ENABLE,
  output logic RETRAIN,
  output logic RX_VALID_OUT,
  output logic RX_ERROR_OUT,
  output logic [3:0] RX_DATA_OUT,
  output logic MII_INPUT_MODE,
  output logic SUPPLY_FAULT_IRQ,
  output logic LINK_DROP_IRQ,
  output logic ILV_SWAPPED,
  output pdiag_strap_t STRAP_CFG
);
  typedef enum logic [2:0] {
    PDIAG_RX_IDLE = 3'b001,
    PDIAG_RX_DATA = 3'b010,
    PDIAG_RX_RESET = 3'b100
  } pdiag_rx_t;

  function automatic logic sync_agree(input logic [2:0] s, input logic prev);
    return (s[1] == s[2]) ? s[2] : prev;
  endfunction

  // swaps the two ternary lanes of a symbol pair
  function automatic pdiag_sym_t swap_sym(input pdiag_sym_t s);
    return pdiag_sym_t'{a: s.b, b: s.a, valid: s.valid};
  endfunction

  // three-stage synchronisers for pins
  logic [2:0] uva18_s_reg, uvd18_s_reg, uva33_s_reg, sok_s_reg;
  logic uva18_reg, uvd18_reg, uva33_reg, sok_reg;
  always_ff @(posedge REF_CLK) begin
    if (RESET) begin
      uva18_s_reg <= 3'h0;
      uvd18_s_reg <= 3'h0;
      uva33_s_reg <= 3'h0;
      sok_s_reg <= 3'h0;
      uva18_reg <= 1'b0;
      uvd18_reg <= 1'b0;
      uva33_reg <= 1'b0;
      sok_reg <= 1'b0;
    end else begin
      uva18_s_reg <= {uva18_s_reg[1:0], UV_A18};
      uvd18_s_reg <= {uvd18_s_reg[1:0], UV_D18};
      uva33_s_reg <= {uva33_s_reg[1:0], UV_A33};
      sok_s_reg <= {sok_s_reg[1:0], SUPPLIES_OK};
      uva18_reg <= sync_agree(uva18_s_reg, uva18_reg);
      uvd18_reg <= sync_agree(uvd18_s_reg, uvd18_reg);
      uva33_reg <= sync_agree(uva33_s_reg, uva33_reg);
      sok_reg <= sync_agree(sok_s_reg, sok_reg);
    end
  end
  logic uv_any;
  assign uv_any = uva18_reg | uvd18_reg | uva33_reg;

  // strap capture after settling
  logic [31:0] pon_cnt_reg;
  logic strap_done_reg;
  always_ff @(posedge REF_CLK) begin
    if (RESET) begin
      pon_cnt_reg <= 32'h0;
      strap_done_reg <= 1'b0;
      STRAP_CFG <= '0;
    end else if (!strap_done_reg && sok_reg) begin
      if (pon_cnt_reg == 32'(PON_CYC - 1)) begin
        strap_done_reg <= 1'b1;
        STRAP_CFG.addr <= {ADDR_STRAP_BIT1, ADDR_STRAP_BIT0};
        STRAP_CFG.role_master <= ROLE_STRAP;
        STRAP_CFG.autonomous <= OPERATION_STRAP;
        STRAP_CFG.iface <= pdiag_if_t'({IFACE_STRAP_HIGH, IFACE_STRAP_LOW});
      end else begin
        pon_cnt_reg <= pon_cnt_reg + 32'h1;
      end
    end
  end
  always_ff @(posedge REF_CLK) begin
    if (RESET) MGMT_ADDR_HIT <= 1'b0;
    else MGMT_ADDR_HIT <= strap_done_reg && (MGMT_ADDR == 5'h00 || MGMT_ADDR == {3'h0, STRAP_CFG.addr});
  end

  // axi-lite slave
  logic [4:0] ctrl_reg;
  logic [7:0] floor_reg;
  logic [7:0] near_cnt_reg, far_cnt_reg;
  logic [2:0] uv_flag_reg;
  logic cbl_open_reg, cbl_short_reg, cbl_done_reg, link_drop_reg;
  logic aw_got_reg, w_got_reg;
  logic [11:0] awaddr_reg;
  logic [31:0] wdata_reg;
  logic wr_fire, rd_fire, rd_cnt_clr;
  assign wr_fire = aw_got_reg && w_got_reg && !S_AXI_BVALID;
  assign rd_fire = S_AXI_ARVALID && S_AXI_ARREADY;
  assign rd_cnt_clr = rd_fire && (S_AXI_ARADDR == `PDIAG_FAILCNT_OFS);
  logic normal_mode;
  assign normal_mode = ctrl_reg[`PDIAG_CTRL_NORMAL] && !uv_any;
  always_ff @(posedge REF_CLK) begin
    if (RESET) begin
      aw_got_reg <= 1'b0;
      w_got_reg <= 1'b0;
      awaddr_reg <= 12'h0;
      wdata_reg <= 32'h0;
      S_AXI_AWREADY <= 1'b0;
      S_AXI_WREADY <= 1'b0;
      S_AXI_BVALID <= 1'b0;
      S_AXI_BRESP <= 2'h0;
    end else begin
      S_AXI_AWREADY <= !aw_got_reg && !S_AXI_AWREADY && S_AXI_AWVALID;
      S_AXI_WREADY <= !w_got_reg && !S_AXI_WREADY && S_AXI_WVALID;
      if (S_AXI_AWVALID && S_AXI_AWREADY) begin
        aw_got_reg <= 1'b1;
        awaddr_reg <= S_AXI_AWADDR;
      end
      if (S_AXI_WVALID && S_AXI_WREADY) begin
        w_got_reg <= 1'b1;
        wdata_reg <= S_AXI_WDATA;
      end
      if (wr_fire) begin
        S_AXI_BVALID <= 1'b1;
        S_AXI_BRESP <= (awaddr_reg == `PDIAG_CTRL_OFS || awaddr_reg == `PDIAG_FLOOR_OFS) ? 2'h0 : 2'h2;
        aw_got_reg <= 1'b0;
        w_got_reg <= 1'b0;
      end else if (S_AXI_BVALID && S_AXI_BREADY) begin
        S_AXI_BVALID <= 1'b0;
      end
    end
  end
  logic cbl_start;
  logic cbl_busy_reg;
  always_ff @(posedge REF_CLK) begin
    if (RESET) begin
      ctrl_reg <= `PDIAG_CTRL_RST;
      floor_reg <= `PDIAG_FLOOR_RST;
    end else begin
      if (wr_fire && awaddr_reg == `PDIAG_CTRL_OFS && S_AXI_WSTRB[0]) begin
        ctrl_reg <= wdata_reg[4:0];
        if (!(wdata_reg[`PDIAG_CTRL_NORMAL] && !uv_any)) ctrl_reg[`PDIAG_CTRL_CABLE] <= 1'b0;
      end else if (cbl_done_reg) begin
        // cable bit self clears once the result is posted
        ctrl_reg[`PDIAG_CTRL_CABLE] <= 1'b0;
      end
      if (uv_any) ctrl_reg[`PDIAG_CTRL_NORMAL] <= 1'b0;
      if (wr_fire && awaddr_reg == `PDIAG_FLOOR_OFS && S_AXI_WSTRB[0]) floor_reg <= wdata_reg[7:0];
    end
  end
  always_ff @(posedge REF_CLK) begin
    if (RESET) begin
      S_AXI_ARREADY <= 1'b0;
      S_AXI_RVALID <= 1'b0;
      S_AXI_RDATA <= 32'h0;
      S_AXI_RRESP <= 2'h0;
    end else begin
      S_AXI_ARREADY <= !S_AXI_ARREADY && !S_AXI_RVALID && S_AXI_ARVALID;
      if (rd_fire) begin
        S_AXI_RVALID <= 1'b1;
        S_AXI_RRESP <= 2'h0;
        unique case (S_AXI_ARADDR)
          `PDIAG_CTRL_OFS: S_AXI_RDATA <= {27'h0, ctrl_reg};
          `PDIAG_STAT_OFS: S_AXI_RDATA <= {29'h0, link_drop_reg, sok_reg, strap_done_reg};
          `PDIAG_EXT_OFS: S_AXI_RDATA <= {25'h0, cbl_done_reg, ILV_SWAPPED, cbl_short_reg, cbl_open_reg, uv_flag_reg};
          `PDIAG_FAILCNT_OFS: S_AXI_RDATA <= {16'h0, near_cnt_reg, far_cnt_reg};
          `PDIAG_SNR_OFS: S_AXI_RDATA <= {24'h0, SNR_IN};
          `PDIAG_FLOOR_OFS: S_AXI_RDATA <= {24'h0, floor_reg};
          `PDIAG_STRAP_OFS: S_AXI_RDATA <= {25'h0, strap_done_reg, STRAP_CFG};
          default: begin
            S_AXI_RDATA <= 32'h0;
            S_AXI_RRESP <= 2'h2;
          end
        endcase
      end else if (S_AXI_RVALID && S_AXI_RREADY) begin
        S_AXI_RVALID <= 1'b0;
      end
    end
  end

  // supply fault flags, cleared on read of external status (set wins)
  logic rd_ext;
  assign rd_ext = rd_fire && (S_AXI_ARADDR == `PDIAG_EXT_OFS);
  always_ff @(posedge REF_CLK) begin
    if (RESET) begin
      uv_flag_reg <= 3'h0;
      SUPPLY_FAULT_IRQ <= 1'b0;
    end else begin
      uv_flag_reg <= (rd_ext ? 3'h0 : uv_flag_reg) | {uva33_reg, uvd18_reg, uva18_reg};
      SUPPLY_FAULT_IRQ <= (uv_any | (|uv_flag_reg)) && !(rd_ext && !uv_any);
    end
  end

  // cable test
  logic [5:0] pulse_cnt_reg;
  logic [31:0] cbl_cnt_reg;
  assign cbl_start = ctrl_reg[`PDIAG_CTRL_CABLE] && normal_mode && !cbl_busy_reg && !cbl_done_reg;
  always_ff @(posedge REF_CLK) begin
    if (RESET) begin
      cbl_busy_reg <= 1'b0;
      cbl_done_reg <= 1'b0;
      cbl_open_reg <= 1'b0;
      cbl_short_reg <= 1'b0;
      cbl_cnt_reg <= 32'h0;
      pulse_cnt_reg <= 6'h0;
      PROBE_PULSE <= 1'b0;
    end else begin
      PROBE_PULSE <= 1'b0;
      if (cbl_start) begin
        cbl_busy_reg <= 1'b1;
        cbl_cnt_reg <= 32'h0;
        pulse_cnt_reg <= 6'h0;
        cbl_open_reg <= 1'b0;
        cbl_short_reg <= 1'b0;
      end else if (cbl_busy_reg) begin
        pulse_cnt_reg <= (pulse_cnt_reg == `PDIAG_PULSE_CYC - 6'd1) ? 6'h0 : pulse_cnt_reg + 6'h1;
        PROBE_PULSE <= normal_mode && (pulse_cnt_reg == 6'h0);
        cbl_open_reg <= cbl_open_reg | ECHO_OPEN;
        cbl_short_reg <= cbl_short_reg | ECHO_SHORT;
        cbl_cnt_reg <= cbl_cnt_reg + 32'h1;
        if (cbl_cnt_reg == 32'(PROBE_TO_CYC - 1) || !normal_mode) begin
          cbl_busy_reg <= 1'b0;
          cbl_done_reg <= 1'b1;
        end
      end else if (!ctrl_reg[`PDIAG_CTRL_CABLE]) begin
        cbl_done_reg <= cbl_done_reg && !rd_ext;
      end
    end
  end

  // link supervision and fail counters
  logic link_up_reg;
  logic link_fail_ev;
  assign link_fail_ev = link_up_reg && (SNR_IN < floor_reg);
  always_ff @(posedge REF_CLK) begin
    if (RESET) begin
      link_up_reg <= 1'b0;
      link_drop_reg <= 1'b0;
      LINK_DROP_IRQ <= 1'b0;
      RETRAIN <= 1'b0;
      near_cnt_reg <= 8'h0;
      far_cnt_reg <= 8'h0;
    end else begin
      RETRAIN <= !link_up_reg && normal_mode && ctrl_reg[`PDIAG_CTRL_LINKEN];
      if (link_fail_ev || !normal_mode) link_up_reg <= 1'b0;
      else if (ctrl_reg[`PDIAG_CTRL_LINKEN] && SNR_IN >= floor_reg) link_up_reg <= 1'b1;
      link_drop_reg <= link_fail_ev | (link_drop_reg && !(rd_fire && S_AXI_ARADDR == `PDIAG_STAT_OFS));
      LINK_DROP_IRQ <= link_fail_ev | (link_drop_reg && !(rd_fire && S_AXI_ARADDR == `PDIAG_STAT_OFS));
      near_cnt_reg <= (rd_cnt_clr ? 8'h0 : near_cnt_reg) + {7'h0, link_fail_ev};
      far_cnt_reg <= (rd_cnt_clr ? 8'h0 : far_cnt_reg) + {7'h0, link_fail_ev};
    end
  end

  // loopback paths, interleave, receive jabber
  pdiag_lb_t lb_mode;
  assign lb_mode = pdiag_lb_t'(ctrl_reg[`PDIAG_CTRL_LB_HI:`PDIAG_CTRL_LB_LO]);
  pdiag_sym_t rx_src;
  assign rx_src = (lb_mode == PDIAG_LB_INTERNAL) ? TX_SYM : LINE_SYM;
  pdiag_rx_t rx_st_reg;
  logic [31:0] rx_cnt_reg;
  logic tx_on;
  assign tx_on = normal_mode && link_up_reg;
  always_ff @(posedge REF_CLK) begin
    if (RESET) begin
      rx_st_reg <= PDIAG_RX_IDLE;
      rx_cnt_reg <= 32'h0;
    end else begin
      unique case (rx_st_reg)
        PDIAG_RX_IDLE: begin
          rx_cnt_reg <= 32'h0;
          if (RX_START && tx_on) rx_st_reg <= PDIAG_RX_DATA;
        end
        PDIAG_RX_DATA: begin
          rx_cnt_reg <= rx_cnt_reg + 32'h1;
          if (END_DELIM_FIRST && END_DELIM_SECOND) rx_st_reg <= PDIAG_RX_IDLE;
          else if (rx_cnt_reg == 32'(RXFRM_TO_CYC - 1) || !tx_on) rx_st_reg <= PDIAG_RX_RESET;
        end
        PDIAG_RX_RESET: rx_st_reg <= PDIAG_RX_IDLE;
        default: rx_st_reg <= PDIAG_RX_IDLE;
      endcase
    end
  end
  always_ff @(posedge REF_CLK) begin
    if (RESET) begin
      PCS_RX_SYM <= '0;
      LINE_TX_SYM <= '0;
      LINE_RX_FROM_TX <= 1'b0;
      TX_ENABLE <= 1'b0;
      ILV_SWAPPED <= 1'b0;
      RX_VALID_OUT <= 1'b0;
      RX_ERROR_OUT <= 1'b0;
      RX_DATA_OUT <= 4'h0;
      MII_INPUT_MODE <= 1'b1;
    end else begin
      TX_ENABLE <= tx_on;
      LINE_RX_FROM_TX <= (lb_mode == PDIAG_LB_EXTERNAL);
      if (rx_src.valid && rx_st_reg == PDIAG_RX_IDLE && RX_START) ILV_SWAPPED <= rx_src.a[1] ^ rx_src.b[1];
      PCS_RX_SYM <= ILV_SWAPPED ? swap_sym(rx_src) : rx_src;
      LINE_TX_SYM <= !tx_on ? '0 : (lb_mode == PDIAG_LB_REMOTE) ? PCS_RX_SYM : TX_SYM;
      MII_INPUT_MODE <= !normal_mode;
      RX_VALID_OUT <= tx_on && rx_st_reg == PDIAG_RX_DATA;
      RX_ERROR_OUT <= tx_on && rx_st_reg == PDIAG_RX_DATA && rx_cnt_reg == 32'(RXFRM_TO_CYC - 1);
      RX_DATA_OUT <= tx_on ? {PCS_RX_SYM.a, PCS_RX_SYM.b} : 4'h0;
    end
  end
endmodule // pdiag_top

// ### bench/pdiag_properties.sv
`timescale 1ns/1ps
module pdiag_properties
  import pdiag_pkg::*;
#(
  parameter int RXFRM_TO_CYC = 4000
) (
  input wire logic REF_CLK,
  input wire logic RESET,
  input wire logic UV_A18,
  input wire logic UV_D18,
  input wire logic UV_A33,
  input wire logic [4:0] MGMT_ADDR,
  input wire logic MGMT_ADDR_HIT,
  input wire logic [7:0] SNR_IN,
  input wire logic PROBE_PULSE,
  input wire logic TX_ENABLE,
  input wire logic RX_VALID_OUT,
  input wire logic RX_ERROR_OUT,
  input wire logic [3:0] RX_DATA_OUT,
  input wire logic MII_INPUT_MODE,
  input wire logic SUPPLY_FAULT_IRQ,
  input wire logic LINK_DROP_IRQ,
  input wire pdiag_strap_t STRAP_CFG
);
  default clocking @(posedge REF_CLK); endclocking
  default disable iff (RESET);
  int vrun_reg;
  // cycles of receive valid in a row
  always_ff @(posedge REF_CLK) begin
    if (RESET || !RX_VALID_OUT) vrun_reg <= 0;
    else vrun_reg <= vrun_reg + 1;
  end
  property p_uv_silent; $rose(UV_A18 || UV_D18 || UV_A33) |-> ##[3:8] !TX_ENABLE; endproperty
  a_uv_silent: assert property (p_uv_silent) else $error("link kept after undervoltage");
  property p_uv_irq; $rose(UV_A18 || UV_D18 || UV_A33) |-> ##[3:8] SUPPLY_FAULT_IRQ; endproperty
  a_uv_irq: assert property (p_uv_irq) else $error("no supply fault flag");
  property p_standby_rx;
    MII_INPUT_MODE && $past(MII_INPUT_MODE) |-> !RX_VALID_OUT && !RX_ERROR_OUT && RX_DATA_OUT == 4'h0;
  endproperty
  a_standby_rx: assert property (p_standby_rx) else $error("receive outputs not low in standby");
  property p_probe_normal; PROBE_PULSE |-> !MII_INPUT_MODE; endproperty
  a_probe_normal: assert property (p_probe_normal) else $error("probe pulse outside normal mode");
  property p_probe_gap; PROBE_PULSE |=> !PROBE_PULSE [*8]; endproperty
  a_probe_gap: assert property (p_probe_gap) else $error("probe pulses too close");
  property p_addr0; MGMT_ADDR == 5'h00 |=> MGMT_ADDR_HIT; endproperty
  a_addr0: assert property (p_addr0) else $error("address zero not answered");
  property p_addr_far; MGMT_ADDR[4:2] != 3'h0 |=> !MGMT_ADDR_HIT; endproperty
  a_addr_far: assert property (p_addr_far) else $error("foreign address answered");
  property p_strap_fixed; STRAP_CFG != '0 |=> $stable(STRAP_CFG); endproperty
  a_strap_fixed: assert property (p_strap_fixed) else $error("strap config changed");
  property p_snr_fail; TX_ENABLE && SNR_IN == 8'h00 |-> ##[1:4] !TX_ENABLE; endproperty
  a_snr_fail: assert property (p_snr_fail) else $error("link kept with noise ratio zero");
  property p_drop_irq; TX_ENABLE && SNR_IN == 8'h00 |-> ##[1:4] LINK_DROP_IRQ; endproperty
  a_drop_irq: assert property (p_drop_irq) else $error("no link drop flag");
  property p_rx_jabber; vrun_reg <= RXFRM_TO_CYC + 8; endproperty
  a_rx_jabber: assert property (p_rx_jabber) else $error("receive data state too long");
  c_probe: cover property (PROBE_PULSE);
  c_drop: cover property (LINK_DROP_IRQ && !TX_ENABLE);
  c_uv: cover property (SUPPLY_FAULT_IRQ && MII_INPUT_MODE);
endmodule // pdiag_properties

// ### bench/pdiag_peer.sv
`timescale 1ns/1ps
module pdiag_peer
  import pdiag_pkg::*;
(
  input wire logic clk,
  input wire logic go,
  input wire logic [7:0] len,
  input wire logic [3:0] sym,
  input wire logic no_end,
  input wire logic cut,
  output pdiag_sym_t line_sym,
  output logic rx_start,
  output logic delim_first,
  output logic delim_second
);
  logic [7:0] cnt_reg = 8'h0;
  logic [1:0] tail_reg = 2'h0;
  logic [3:0] junk_reg = 4'h5;
  initial begin
    line_sym = '0;
    rx_start = 1'b0;
    delim_first = 1'b0;
    delim_second = 1'b0;
  end
  always @(posedge clk) begin
    junk_reg <= ~junk_reg + 4'h3;
    rx_start <= go && !cut;
    delim_first <= tail_reg != 2'h0;
    delim_second <= tail_reg == 2'h1;
    if (tail_reg != 2'h0) tail_reg <= tail_reg - 2'h1;
    if (go && !cut) cnt_reg <= len;
    else if (cnt_reg != 8'h0) begin
      cnt_reg <= cnt_reg - 8'h1;
      if (cnt_reg == 8'h1 && !no_end) tail_reg <= 2'h2;
    end
    // idle line moves every cycle, so no stale symbol survives
    if ((go && !cut) || cnt_reg > 8'h1) line_sym <= '{sym[3:2], sym[1:0], 1'b1};
    else line_sym <= '{junk_reg[3:2], junk_reg[1:0], 1'b0};
  end
endmodule // pdiag_peer

// ### bench/tb_top.sv
`timescale 1ns/1ps
`include "pdiag_map.svh"
`define CHK(g, e) begin checks_done++; if ((g) !== (e)) begin mismatches++; \
  $display("ERROR t=%0t got=%h exp=%h", $time, (g), (e)); end end
module tb_top;
  import pdiag_pkg::*;
  localparam int PTO = 150;
  localparam int RTO = 24;
  integer seed = 32'hbf4e;
  int mismatches = 0, checks_done = 0, cycles = 0;
  logic clk = 1'b0, rst = 1'b1, go = 1'b0, no_end = 1'b0, cut = 1'b0, eo = 1'b0, es = 1'b0;
  logic awv = 1'b0, wv = 1'b0, bry = 1'b0, arv = 1'b0, rry = 1'b0;
  logic awr, wry, bv, arr, rv, rxs, ed1, ed2, lrft, probe, txen, retrain, rxv, mii_in, uv_irq, drop, ilv, hit;
  logic [11:0] awa = 12'h0, ara = 12'h0;
  logic [31:0] wd = 32'h0, rdat, rd_o;
  logic [1:0] bres, rres, br_o, rr_o;
  logic [2:0] uv = 3'h0;
  logic [5:0] st = 6'h0;
  logic [4:0] ma = 5'h10;
  logic [7:0] snr = 8'h80, plen = 8'h0;
  logic [3:0] psym = 4'h0;
  pdiag_sym_t tx = '0, lsym, pcs, ltx;
  pdiag_strap_t scfg;
  pdiag_top #(.PROBE_TO_CYC(PTO), .RXFRM_TO_CYC(RTO), .PON_CYC(16)) dut_u (
    .REF_CLK(clk), .RESET(rst), .S_AXI_AWADDR(awa), .S_AXI_AWVALID(awv), .S_AXI_AWREADY(awr),
    .S_AXI_WDATA(wd), .S_AXI_WSTRB(4'hf), .S_AXI_WVALID(wv), .S_AXI_WREADY(wry), .S_AXI_BRESP(br_o),
    .S_AXI_BVALID(bv), .S_AXI_BREADY(bry), .S_AXI_ARADDR(ara), .S_AXI_ARVALID(arv), .S_AXI_ARREADY(arr),
    .S_AXI_RDATA(rd_o), .S_AXI_RRESP(rr_o), .S_AXI_RVALID(rv), .S_AXI_RREADY(rry),
    .UV_A18(uv[0]), .UV_D18(uv[1]), .UV_A33(uv[2]), .SUPPLIES_OK(1'b1),
    .ADDR_STRAP_BIT0(st[0]), .ADDR_STRAP_BIT1(st[1]), .ROLE_STRAP(st[2]), .OPERATION_STRAP(st[3]),
    .IFACE_STRAP_LOW(st[4]), .IFACE_STRAP_HIGH(st[5]), .MGMT_ADDR(ma), .MGMT_ADDR_HIT(hit),
    .SNR_IN(snr), .ECHO_OPEN(eo), .ECHO_SHORT(es), .TX_SYM(tx), .LINE_SYM(lsym),
    .END_DELIM_FIRST(ed1), .END_DELIM_SECOND(ed2), .RX_START(rxs), .PCS_RX_SYM(pcs), .LINE_TX_SYM(ltx),
    .LINE_RX_FROM_TX(lrft), .PROBE_PULSE(probe), .TX_ENABLE(txen), .RETRAIN(retrain), .RX_VALID_OUT(rxv),
    .RX_ERROR_OUT(), .RX_DATA_OUT(), .MII_INPUT_MODE(mii_in), .SUPPLY_FAULT_IRQ(uv_irq),
    .LINK_DROP_IRQ(drop), .ILV_SWAPPED(ilv), .STRAP_CFG(scfg));
  pdiag_peer peer_u (.clk(clk), .go(go), .len(plen), .sym(psym), .no_end(no_end), .cut(cut),
    .line_sym(lsym), .rx_start(rxs), .delim_first(ed1), .delim_second(ed2));
  always #12.5 clk = ~clk;
  task automatic end_sim();
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      mismatches++;
      end_sim();
    end
  end
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic axw(input logic [11:0] a, input logic [31:0] d);
    awa <= a;
    wd <= d;
    awv <= 1'b1;
    wv <= 1'b1;
    bry <= 1'b1;
    do begin
      @(posedge clk);
      if (awr) awv <= 1'b0;
      if (wry) wv <= 1'b0;
    end while (!bv);
    bres = br_o;
    bry <= 1'b0;
    @(posedge clk);
  endtask
  task automatic axr(input logic [11:0] a);
    ara <= a;
    arv <= 1'b1;
    rry <= 1'b1;
    do begin
      @(posedge clk);
      if (arr) arv <= 1'b0;
    end while (!rv);
    rdat = rd_o;
    rres = rr_o;
    rry <= 1'b0;
    @(posedge clk);
  endtask
  task automatic frame(input logic [3:0] sy, input logic [7:0] n, input logic ne);
    psym <= sy;
    plen <= n;
    no_end <= ne;
    go <= 1'b1;
    cyc(1);
    go <= 1'b0;
  endtask
  function automatic pdiag_strap_t exp_strap(input logic [5:0] s);
    pdiag_if_t f;
    f = s[5] ? (s[4] ? PDIAG_IF_REV_MII : PDIAG_IF_RMII_XTAL) : (s[4] ? PDIAG_IF_RMII_OSC : PDIAG_IF_MII);
    return '{addr: {s[1], s[0]}, role_master: s[2], autonomous: s[3], iface: f};
  endfunction
  initial begin
    logic [31:0] r;
    pdiag_sym_t ts;
    pdiag_sym_t xs;
    int n;
    logic f, v;
    for (int i = 0; i < 4; i++) begin
      r = $random(seed);
      r[5:4] = i[1:0];
      rst <= 1'b1;
      st <= r[5:0];
      cyc(16);
      rst <= 1'b0;
      cyc(40);
      `CHK(scfg, exp_strap(r[5:0]))
      axr(`PDIAG_STRAP_OFS);
      `CHK(rdat, {25'h0, 1'b1, exp_strap(r[5:0])})
      ma <= {3'h0, r[1:0]};
      cyc(2);
      `CHK(hit, 1'b1)
      ma <= 5'h00;
      cyc(2);
      `CHK(hit, 1'b1)
      ma <= {3'h4, r[1:0]};
      cyc(2);
      `CHK(hit, 1'b0)
    end
    $display("test straps done");
    axr(12'h100);
    `CHK(rres, 2'h2)
    axw(`PDIAG_SNR_OFS, 32'h0);
    `CHK(bres, 2'h2)
    axr(`PDIAG_FLOOR_OFS);
    `CHK(rdat, {24'h0, `PDIAG_FLOOR_RST})
    axw(`PDIAG_FLOOR_OFS, 32'h40);
    r = $random(seed);
    snr <= 8'h40 + {1'b0, r[6:0]};
    cyc(2);
    axr(`PDIAG_SNR_OFS);
    `CHK(rdat[7:0], 8'h40 + {1'b0, r[6:0]})
    axr(`PDIAG_FAILCNT_OFS);
    for (int k = 0; k < 2; k++) begin
      snr <= 8'h40;
      axw(`PDIAG_CTRL_OFS, 32'h5);
      cyc(6);
      `CHK(txen, 1'b1)
      `CHK(mii_in, 1'b0)
      snr <= k ? 8'h3f : 8'h00;
      cyc(8);
      `CHK(txen, 1'b0)
      `CHK(drop, 1'b1)
      `CHK(retrain, 1'b1)
      axr(`PDIAG_FAILCNT_OFS);
      `CHK(rdat[15:0], 16'h0101)
    end
    axr(`PDIAG_FAILCNT_OFS);
    `CHK(rdat[15:0], 16'h0000)
    axw(`PDIAG_CTRL_OFS, 32'h1);
    cyc(4);
    `CHK(retrain, 1'b0)
    $display("test link fail done");
    snr <= 8'h80;
    axw(`PDIAG_CTRL_OFS, 32'h5);
    cyc(6);
    for (int k = 0; k < 2; k++) begin
      frame(k ? 4'b1001 : 4'b1010, 8'd6, 1'b0);
      cyc(14);
      `CHK(ilv, k[0])
    end
    frame(4'b0101, 8'd60, 1'b1);
    cyc(5);
    `CHK(rxv, 1'b1)
    cyc(RTO + 11);
    `CHK(rxv, 1'b0)
    cyc(30);
    $display("test receive done");
    axw(`PDIAG_CTRL_OFS, 32'h2);
    axr(`PDIAG_CTRL_OFS);
    `CHK(rdat[1], 1'b0)
    r = $random(seed);
    eo <= r[0];
    es <= r[1];
    axw(`PDIAG_CTRL_OFS, 32'h3);
    while (!probe) cyc(1);
    n = 0;
    do begin
      cyc(1);
      n++;
    end while (!probe);
    `CHK(n, 60)
    cyc(PTO);
    axr(`PDIAG_EXT_OFS);
    `CHK({rdat[`PDIAG_EXT_DONE], rdat[4:3]}, {1'b1, r[1:0]})
    $display("test cable done");
    for (int m = 1; m < 4; m++) begin
      axw(`PDIAG_CTRL_OFS, {27'h0, m[1:0], 3'h1});
      axw(`PDIAG_CTRL_OFS, {27'h0, m[1:0], 3'h5});
      cut <= (m == 2);
      r = $random(seed);
      ts = '{r[3:2], r[1:0], 1'b1};
      xs = (m == 3 && (r[3] ^ r[1])) ? pdiag_sym_t'{r[1:0], r[3:2], 1'b1} : ts;
      tx <= (m == 3) ? '0 : ts;
      if (m == 3) frame(r[3:0], 8'd10, 1'b0);
      f = 1'b0;
      v = 1'b0;
      repeat (12) begin
        cyc(1);
        if (((m == 1) ? pcs : ltx) === xs) f = 1'b1;
        v = v | rxv;
      end
      `CHK(f, 1'b1)
      `CHK(lrft, m == 2)
      if (m == 3) `CHK(v, 1'b1)
    end
    cut <= 1'b0;
    $display("test loopback done");
    axr(`PDIAG_EXT_OFS);
    for (int i = 0; i < 3; i++) begin
      axw(`PDIAG_CTRL_OFS, 32'h5);
      cyc(6);
      uv <= 3'h1 << i;
      cyc(10);
      `CHK(txen, 1'b0)
      `CHK(mii_in, 1'b1)
      `CHK(uv_irq, 1'b1)
      uv <= 3'h0;
      cyc(6);
      axr(`PDIAG_EXT_OFS);
      `CHK(rdat[2:0], 3'h1 << i)
    end
    $display("test supply done");
    end_sim();
  end
endmodule // tb_top
bind pdiag_top pdiag_properties #(.RXFRM_TO_CYC(RXFRM_TO_CYC)) chk_u (.*);
